// ===== verilog/fc_inj_pkg.sv
/*
 * Constants, register map and encodings for the Fibre Channel alarm and
 * error injector. Assumes a 10 MHz port transmit clock and 32-bit words
 * carrying four 8b code groups, the first transmitted byte in bits 31:24.
 */
package fc_inj_pkg;

    // Timing
    localparam int CLK_FREQ_HZ = 10000000;
    localparam int BURST_SEC_PERIOD_S = 1;
    localparam int BURST_10SEC_PERIOD_S = 10;
    localparam int SEC_CYCLES = BURST_SEC_PERIOD_S * CLK_FREQ_HZ;
    localparam int TEN_SEC_CYCLES = BURST_10SEC_PERIOD_S * CLK_FREQ_HZ;
    localparam int FIFO_DEPTH = 4;

    // Register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] BURST_OFS = 8'h04;
    localparam logic [7:0] TRIG_OFS = 8'h08;
    localparam logic [7:0] FREQ_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] ERRCNT_OFS = 8'h14;

    // Field positions
    localparam int ALARM_LSB = 0;
    localparam int ERR_LSB = 4;
    localparam int MODE_LSB = 8;
    localparam int RATE_LSB = 12;
    localparam int HDRONLY_BIT = 16;
    localparam int TRIG_BIT = 0;

    // Reset values
    localparam logic [15:0] BURST_RST = 16'h0001;
    localparam logic [15:0] FREQ_RST = 16'h0000;

    typedef enum logic [2:0] {ALARM_NONE, ALARM_LINK_RESET, ALARM_LINK_RESET_RESP, ALARM_NOT_OPER,
                              ALARM_OFFLINE} alarm_t;
    typedef enum logic [2:0] {ERR_NONE, ERR_BIT, ERR_SYMBOL, ERR_RRDY, ERR_CRC, ERR_BLOCK} err_t;
    typedef enum logic [3:0] {INS_OFF, INS_MANUAL, INS_PER_SEC, INS_PER_10SEC, INS_RATIO_E2, INS_RATIO_E3,
                              INS_RATIO_E4, INS_RATIO_E5, INS_RATIO_E6, INS_RATIO_E7} ins_mode_t;
    typedef enum logic [1:0] {RATE_STD, RATE_MODE_1200, RATE_MODE_1600} rate_t;
    typedef enum logic [1:0] {FIELD_CTRL, FIELD_HEADER, FIELD_PAYLOAD, FIELD_CRC} field_t;

    // Code groups
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] D9_2 = 8'h49;
    localparam logic [7:0] D31_5 = 8'hbf;
    localparam logic [7:0] D21_1 = 8'h35;
    localparam logic [7:0] D21_2 = 8'h55;
    localparam logic [7:0] D5_2 = 8'h45;
    localparam logic [7:0] D10_4 = 8'h8a;
    localparam logic [7:0] D21_4 = 8'h95;
    localparam logic [7:0] D10_2 = 8'h4a;
    localparam logic [3:0] OS_K_MASK = 4'h8;
    localparam logic [31:0] BIT_FLIP_MASK = 32'h0000_0001;
    localparam logic [3:0] SYM_ERR_MASK = 4'h1;

    // Transmitted words between burst starts in ratio modes
    localparam logic [31:0] RATIO_E2 = 32'h64;
    localparam logic [31:0] RATIO_E3 = 32'h3e8;
    localparam logic [31:0] RATIO_E4 = 32'h2710;
    localparam logic [31:0] RATIO_E5 = 32'h186a0;
    localparam logic [31:0] RATIO_E6 = 32'hf4240;
    localparam logic [31:0] RATIO_E7 = 32'h989680;

endpackage : fc_inj_pkg

// ===== verilog/tx_word_fifo.sv
/*
 * Small synchronous FIFO for transmit words, valid/ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
module tx_word_fifo #(
    parameter int WIDTH = 38,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic in_ready_r;
    wire push = in_valid_in & in_ready_r;
    wire pop = out_valid_out & out_ready_in;

    assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_valid_out = (count_r != '0);
    assign out_data_out = mem_r[rd_ptr_r];
    assign in_ready_out = in_ready_r;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready_r <= 1'b1;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_r + AW'(push);
            rd_ptr_r <= rd_ptr_r + AW'(pop);
            count_r <= count_nxt;
            // Ready is registered so the source sees a flop, not a compare
            in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

endmodule : tx_word_fifo

// ===== verilog/fc_error_alarm_injector.sv
/*
 * Transmit-side alarm and error injector for a Fibre Channel test port,
 * with an APB register slave. Assumes an upstream word source and a
 * downstream 8b/10b or 64b/66b encoder that honours the symbol and block
 * corrupt flags, and a clock synthesiser that takes the deviation word.
 */
// What this block does
// - A selected alarm replaces traffic with its ordered set; none inserts nothing.
// - Link reset alarm sends K28.5 D9.2 D31.5 D9.2 repeatedly.
// - Link reset response alarm sends K28.5 D21.1 D31.5 D9.2 repeatedly.
// - Not-operational alarm sends K28.5 D21.2 D31.5 D5.2 repeatedly.
// - Offline alarm sends K28.5 D21.1 D10.4 D21.2 repeatedly.
// - Bit error flips one payload bit, never header, CRC or delimiters.
// - Symbol error makes one code group undecodable; not in 64b/66b rate modes.
// - Receiver-ready error inserts one extra K28.5 D21.4 D10.2 D10.2 word.
// - CRC error flips one CRC bit; unavailable in header-only framing.
// - Block error corrupts one 64b/66b block; only in 1200 and 1600 modes.
// - Insertion mode off inserts no errors, except one word in the cycle after it is selected while a burst runs.
// - Manual mode inserts one burst per single insert trigger.
// - Per-second mode inserts one burst every second.
// - Ten-second mode inserts one burst every ten seconds.
// - Ratio modes insert one burst per reciprocal-of-ratio transmitted words.
// - Insert trigger is ignored in ratio modes; status shows insertion active.
// - Signed deviation raises or lowers the transmit frequency.
`timescale 1ns/1ps
module fc_error_alarm_injector #(
    parameter int FIFO_DEPTH = fc_inj_pkg::FIFO_DEPTH,
    parameter int SEC_CYCLES = fc_inj_pkg::SEC_CYCLES,
    parameter int TEN_SEC_CYCLES = fc_inj_pkg::TEN_SEC_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Traffic in
    input wire logic [31:0] tx_data_in,
    input wire logic [3:0] tx_k_in,
    input wire logic [1:0] tx_field_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    // Traffic out
    output logic [31:0] tx_data_out,
    output logic [3:0] tx_k_out,
    output logic [1:0] tx_field_out,
    output logic [3:0] tx_sym_err_out,
    output logic tx_blk_err_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    // Frequency control
    output logic [15:0] tx_freq_dev_out
);

    function automatic fc_inj_pkg::err_t legal_err(input fc_inj_pkg::err_t e, input fc_inj_pkg::rate_t r,
                                                   input logic hdr_only);
        logic hi_rate;
        hi_rate = (r == fc_inj_pkg::RATE_MODE_1200) || (r == fc_inj_pkg::RATE_MODE_1600);
        legal_err = e;
        if (e == fc_inj_pkg::ERR_SYMBOL && hi_rate)
        begin
            legal_err = fc_inj_pkg::ERR_NONE;
        end
        if (e == fc_inj_pkg::ERR_CRC && hdr_only)
        begin
            legal_err = fc_inj_pkg::ERR_NONE;
        end
        if (e == fc_inj_pkg::ERR_BLOCK && !hi_rate)
        begin
            legal_err = fc_inj_pkg::ERR_NONE;
        end
    endfunction : legal_err

    function automatic logic word_hits(input fc_inj_pkg::err_t e, input fc_inj_pkg::field_t f);
        case (e)
            fc_inj_pkg::ERR_BIT: word_hits = (f == fc_inj_pkg::FIELD_PAYLOAD);
            fc_inj_pkg::ERR_CRC: word_hits = (f == fc_inj_pkg::FIELD_CRC);
            fc_inj_pkg::ERR_SYMBOL, fc_inj_pkg::ERR_BLOCK: word_hits = 1'b1;
            default: word_hits = 1'b0;
        endcase
    endfunction : word_hits

    function automatic logic [31:0] alarm_word(input fc_inj_pkg::alarm_t a);
        case (a)
            fc_inj_pkg::ALARM_LINK_RESET:
                alarm_word = {fc_inj_pkg::K28_5, fc_inj_pkg::D9_2, fc_inj_pkg::D31_5, fc_inj_pkg::D9_2};
            fc_inj_pkg::ALARM_LINK_RESET_RESP:
                alarm_word = {fc_inj_pkg::K28_5, fc_inj_pkg::D21_1, fc_inj_pkg::D31_5, fc_inj_pkg::D9_2};
            fc_inj_pkg::ALARM_NOT_OPER:
                alarm_word = {fc_inj_pkg::K28_5, fc_inj_pkg::D21_2, fc_inj_pkg::D31_5, fc_inj_pkg::D5_2};
            fc_inj_pkg::ALARM_OFFLINE:
                alarm_word = {fc_inj_pkg::K28_5, fc_inj_pkg::D21_1, fc_inj_pkg::D10_4, fc_inj_pkg::D21_2};
            default:
                alarm_word = 32'h0000_0000;
        endcase
    endfunction : alarm_word

    function automatic logic [31:0] ratio_period(input fc_inj_pkg::ins_mode_t m);
        case (m)
            fc_inj_pkg::INS_RATIO_E2: ratio_period = fc_inj_pkg::RATIO_E2;
            fc_inj_pkg::INS_RATIO_E3: ratio_period = fc_inj_pkg::RATIO_E3;
            fc_inj_pkg::INS_RATIO_E4: ratio_period = fc_inj_pkg::RATIO_E4;
            fc_inj_pkg::INS_RATIO_E5: ratio_period = fc_inj_pkg::RATIO_E5;
            fc_inj_pkg::INS_RATIO_E6: ratio_period = fc_inj_pkg::RATIO_E6;
            default: ratio_period = fc_inj_pkg::RATIO_E7;
        endcase
    endfunction : ratio_period

    // Registers
    fc_inj_pkg::alarm_t alarm_r;
    fc_inj_pkg::err_t err_r;
    fc_inj_pkg::ins_mode_t mode_r;
    fc_inj_pkg::rate_t rate_r;
    logic hdr_only_r;
    logic [15:0] burst_len_r;
    logic [15:0] freq_r;
    logic [31:0] err_cnt_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // Insertion state
    logic [15:0] burst_left_r;
    logic [31:0] per_cnt_r;
    logic [31:0] blk_cnt_r;

    // Output stage
    logic [31:0] out_data_r;
    logic [3:0] out_k_r;
    logic [1:0] out_field_r;
    logic [3:0] out_sym_r;
    logic out_blk_r;
    logic out_valid_r;

    // FIFO drain side
    logic [37:0] f_word;
    logic f_valid;
    logic f_ready;
    wire [31:0] f_data = f_word[31:0];
    wire [3:0] f_k = f_word[35:32];
    wire fc_inj_pkg::field_t f_field = fc_inj_pkg::field_t'(f_word[37:36]);

    tx_word_fifo #(
        .WIDTH(38),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .in_data_in({tx_field_in, tx_k_in, tx_data_in}),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .out_data_out(f_word),
        .out_valid_out(f_valid),
        .out_ready_in(f_ready)
    );

    // Bus decode
    wire acc = psel_in & penable_in;
    wire wr_now = acc & pwrite_in & pready_r;
    wire addr_ok = (paddr_in <= fc_inj_pkg::ERRCNT_OFS) && (paddr_in[1:0] == 2'b00);
    wire wr_ctrl = wr_now & (paddr_in == fc_inj_pkg::CTRL_OFS);
    wire wr_burst = wr_now & (paddr_in == fc_inj_pkg::BURST_OFS);
    wire wr_trig = wr_now & (paddr_in == fc_inj_pkg::TRIG_OFS) & pwdata_in[fc_inj_pkg::TRIG_BIT];
    wire wr_freq = wr_now & (paddr_in == fc_inj_pkg::FREQ_OFS);
    wire wr_errcnt = wr_now & (paddr_in == fc_inj_pkg::ERRCNT_OFS);

    // Insertion control
    wire fc_inj_pkg::err_t eff_err = legal_err(err_r, rate_r, hdr_only_r);
    wire alarm_on = (alarm_r != fc_inj_pkg::ALARM_NONE);
    wire ins_on = (mode_r != fc_inj_pkg::INS_OFF);
    wire is_periodic = (mode_r == fc_inj_pkg::INS_PER_SEC) || (mode_r == fc_inj_pkg::INS_PER_10SEC);
    wire is_ratio = (mode_r >= fc_inj_pkg::INS_RATIO_E2) && (mode_r <= fc_inj_pkg::INS_RATIO_E7);
    wire [31:0] per_limit = (mode_r == fc_inj_pkg::INS_PER_SEC) ? 32'(SEC_CYCLES) : 32'(TEN_SEC_CYCLES);
    wire per_hit = is_periodic & (per_cnt_r == per_limit - 32'h1);
    wire manual_hit = wr_trig & (mode_r == fc_inj_pkg::INS_MANUAL);
    wire burst_busy = (burst_left_r != 16'h0000);
    wire err_armed = ins_on & (eff_err != fc_inj_pkg::ERR_NONE);

    // Traffic path
    wire adv = ~out_valid_r | tx_ready_in;
    wire rrdy_go = ~alarm_on & (eff_err == fc_inj_pkg::ERR_RRDY) & burst_busy;
    wire take_fifo = adv & ~alarm_on & ~rrdy_go & f_valid;
    wire hit_word = take_fifo & burst_busy & word_hits(eff_err, f_field);
    wire consume = (adv & rrdy_go) | hit_word;
    wire ratio_hit = is_ratio & take_fifo & (blk_cnt_r == ratio_period(mode_r) - 32'h1);
    wire trig = err_armed & ~burst_busy & (manual_hit | per_hit | ratio_hit);

    // Alarm stalls the FIFO so the source sees back-pressure, not silent loss
    assign f_ready = adv & ~alarm_on & ~rrdy_go;

    wire [31:0] corrupt_mask = (hit_word && (eff_err == fc_inj_pkg::ERR_BIT || eff_err == fc_inj_pkg::ERR_CRC)) ?
                               fc_inj_pkg::BIT_FLIP_MASK : 32'h0000_0000;
    wire [3:0] sym_nxt = (hit_word && eff_err == fc_inj_pkg::ERR_SYMBOL) ? fc_inj_pkg::SYM_ERR_MASK : 4'h0;
    wire blk_nxt = hit_word && (eff_err == fc_inj_pkg::ERR_BLOCK);
    wire [31:0] rrdy_word = {fc_inj_pkg::K28_5, fc_inj_pkg::D21_4, fc_inj_pkg::D10_2, fc_inj_pkg::D10_2};

    wire [31:0] ctrl_word = {15'h0000, hdr_only_r, 2'b00, rate_r, mode_r, 1'b0, err_r, 1'b0, alarm_r};
    wire [31:0] status_word = {burst_left_r, 13'h0000, alarm_on, ins_on & burst_busy, err_armed};
    wire [31:0] rd_word = (paddr_in == fc_inj_pkg::CTRL_OFS) ? ctrl_word :
                          (paddr_in == fc_inj_pkg::BURST_OFS) ? {16'h0000, burst_len_r} :
                          (paddr_in == fc_inj_pkg::FREQ_OFS) ? {16'h0000, freq_r} :
                          (paddr_in == fc_inj_pkg::STATUS_OFS) ? status_word :
                          (paddr_in == fc_inj_pkg::ERRCNT_OFS) ? err_cnt_r : 32'h0000_0000;

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign tx_data_out = out_data_r;
    assign tx_k_out = out_k_r;
    assign tx_field_out = out_field_r;
    assign tx_sym_err_out = out_sym_r;
    assign tx_blk_err_out = out_blk_r;
    assign tx_valid_out = out_valid_r;
    assign tx_freq_dev_out = freq_r;

    // APB: one wait state, answer in the second access cycle
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~addr_ok;
            if (acc && !pready_r && !pwrite_in)
            begin
                prdata_r <= rd_word;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            alarm_r <= fc_inj_pkg::ALARM_NONE;
            err_r <= fc_inj_pkg::ERR_NONE;
            mode_r <= fc_inj_pkg::INS_OFF;
            rate_r <= fc_inj_pkg::RATE_STD;
            hdr_only_r <= 1'b0;
            burst_len_r <= fc_inj_pkg::BURST_RST;
            freq_r <= fc_inj_pkg::FREQ_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                alarm_r <= fc_inj_pkg::alarm_t'(pwdata_in[fc_inj_pkg::ALARM_LSB +: 3]);
                err_r <= fc_inj_pkg::err_t'(pwdata_in[fc_inj_pkg::ERR_LSB +: 3]);
                mode_r <= fc_inj_pkg::ins_mode_t'(pwdata_in[fc_inj_pkg::MODE_LSB +: 4]);
                rate_r <= fc_inj_pkg::rate_t'(pwdata_in[fc_inj_pkg::RATE_LSB +: 2]);
                hdr_only_r <= pwdata_in[fc_inj_pkg::HDRONLY_BIT];
            end
            if (wr_burst)
            begin
                burst_len_r <= pwdata_in[15:0];
            end
            if (wr_freq)
            begin
                freq_r <= pwdata_in[15:0];
            end
        end
    end

    // Burst engine; a trigger that lands during a running burst is dropped
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            burst_left_r <= 16'h0000;
            per_cnt_r <= 32'h0000_0000;
            blk_cnt_r <= 32'h0000_0000;
            err_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            if (!err_armed)
            begin
                burst_left_r <= 16'h0000;
            end
            else if (trig)
            begin
                burst_left_r <= burst_len_r;
            end
            else if (consume)
            begin
                burst_left_r <= burst_left_r - 16'h0001;
            end
            per_cnt_r <= (!is_periodic || per_hit) ? 32'h0000_0000 : per_cnt_r + 32'h0000_0001;
            if (!is_ratio || ratio_hit)
            begin
                blk_cnt_r <= 32'h0000_0000;
            end
            else if (take_fifo)
            begin
                blk_cnt_r <= blk_cnt_r + 32'h0000_0001;
            end
            // Counter write clears it; a simultaneous error still counts
            if (consume && err_armed)
            begin
                err_cnt_r <= (wr_errcnt ? 32'h0000_0000 : err_cnt_r) + 32'h0000_0001;
            end
            else if (wr_errcnt)
            begin
                err_cnt_r <= 32'h0000_0000;
            end
        end
    end

    // Output word register; every source fills a whole word
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            out_data_r <= 32'h0000_0000;
            out_k_r <= 4'h0;
            out_field_r <= 2'b00;
            out_sym_r <= 4'h0;
            out_blk_r <= 1'b0;
            out_valid_r <= 1'b0;
        end
        else if (adv)
        begin
            if (alarm_on || rrdy_go)
            begin
                out_data_r <= alarm_on ? alarm_word(alarm_r) : rrdy_word;
                out_k_r <= fc_inj_pkg::OS_K_MASK;
                out_field_r <= fc_inj_pkg::FIELD_CTRL;
                out_sym_r <= 4'h0;
                out_blk_r <= 1'b0;
                out_valid_r <= 1'b1;
            end
            else
            begin
                out_data_r <= f_data ^ corrupt_mask;
                out_k_r <= f_k;
                out_field_r <= f_field;
                out_sym_r <= sym_nxt;
                out_blk_r <= blk_nxt;
                out_valid_r <= f_valid;
            end
        end
    end

endmodule : fc_error_alarm_injector

// ===== testbench/fc_inj_properties.sv
/* Port checker for the alarm and error injector.
   Assumes APB writes land at the edge where pready is high. */
`timescale 1ns/1ps
module fc_inj_properties (
    // Clock, reset and APB
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Transmit side
    input wire logic [31:0] tx_data_out,
    input wire logic [3:0] tx_k_out,
    input wire logic [3:0] tx_sym_err_out,
    input wire logic tx_blk_err_out,
    input wire logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [15:0] tx_freq_dev_out
);
    logic [31:0] ctrl_r;
    logic hs_r;
    wire wr_acc = psel_in & penable_in & pready_out & pwrite_in;
    wire ctrl_wr = wr_acc && paddr_in == fc_inj_pkg::CTRL_OFS;
    wire [2:0] alarm = ctrl_r[2:0];
    wire [1:0] rate = ctrl_r[13:12];
    always_ff @(posedge mclk_in or posedge rst_in)
        if (rst_in) ctrl_r <= '0;
        else if (ctrl_wr) ctrl_r <= pwdata_in;
    // Words already in the output register when CTRL changes are exempt
    always_ff @(posedge mclk_in or posedge rst_in)
        if (rst_in) hs_r <= 1'b0;
        else hs_r <= !ctrl_wr && (hs_r || (tx_valid_out && tx_ready_in));
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    a_lr_word: assert property (
        hs_r && alarm == 3'h1 && tx_valid_out |-> tx_k_out == 4'h8 && tx_data_out == 32'hbc49bf49)
        else $error("link reset word wrong");
    a_lrr_word: assert property (
        hs_r && alarm == 3'h2 && tx_valid_out |-> tx_k_out == 4'h8 && tx_data_out == 32'hbc35bf49)
        else $error("link reset response word wrong");
    a_nos_word: assert property (
        hs_r && alarm == 3'h3 && tx_valid_out |-> tx_k_out == 4'h8 && tx_data_out == 32'hbc55bf45)
        else $error("not operational word wrong");
    a_ols_word: assert property (
        hs_r && alarm == 3'h4 && tx_valid_out |-> tx_k_out == 4'h8 && tx_data_out == 32'hbc358a55)
        else $error("offline word wrong");
    a_word_held: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out) && $stable(tx_k_out))
        else $error("word changed while stalled");
    a_off_clean: assert property (
        hs_r && ctrl_r[11:8] == 4'h0 |-> tx_sym_err_out == 4'h0 && !tx_blk_err_out)
        else $error("error flag with insertion off");
    a_sym_rate: assert property (
        hs_r && rate != 2'h0 |-> tx_sym_err_out == 4'h0)
        else $error("symbol error in block coded rate");
    a_blk_rate: assert property (
        hs_r && rate == 2'h0 |-> !tx_blk_err_out)
        else $error("block error in standard rate");
    a_freq_load: assert property (
        wr_acc && paddr_in == fc_inj_pkg::FREQ_OFS |=> tx_freq_dev_out == $past(pwdata_in[15:0]))
        else $error("deviation not loaded");
    c_alarm: cover property (hs_r && alarm != 3'h0 && tx_valid_out && tx_ready_in);
    c_sym: cover property (tx_sym_err_out != 4'h0);
    c_slverr: cover property (pslverr_out);
endmodule : fc_inj_properties

bind fc_error_alarm_injector fc_inj_properties u_props (.*);

// ===== testbench/fc_port_model.sv
/* Far-side port model: takes words, counts corrupted ones.
   Assumes the bench steers stalls and slow answers. */
`timescale 1ns/1ps
module fc_port_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Words from the injector
    input wire logic [31:0] data_in,
    input wire logic [3:0] k_in,
    input wire logic [3:0] sym_in,
    input wire logic blk_in,
    input wire logic valid_in,
    output logic ready_out,
    // Bench control and results
    input wire logic stall_in,
    input wire logic slow_in,
    output logic [31:0] hits_out,
    output logic [31:0] last_out,
    output logic [3:0] last_k_out
);
    logic tog_r;
    // Traffic has bit0 clear, so a set bit0 means a flip
    wire hit = data_in[0] | (|sym_in) | blk_in | (data_in == 32'hbc954a4a && k_in == 4'h8);
    assign ready_out = !stall_in && (!slow_in || tog_r);
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in) tog_r <= 1'b0;
        else tog_r <= ~tog_r;
    always_ff @(posedge clk_in or posedge rst_in)
        if (rst_in) hits_out <= '0;
        else if (valid_in && ready_out) hits_out <= hits_out + {31'h0, hit};
    always_ff @(posedge clk_in)
        if (valid_in && ready_out) {last_out, last_k_out} <= {data_in, k_in};
endmodule : fc_port_model

// ===== testbench/tb_top.sv
/* Self-checking bench for the injector.
   Assumes shortened second periods of 50 and 500 cycles. */
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [31:0] ctrl; logic [1:0] fld; logic [31:0] len; int trig; int cyc; logic [31:0] exp;} row_t;
    logic mclk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic src_valid = 1'b0, stall = 1'b0, slow = 1'b0, e;
    logic pready, pslverr, tx_ready_out, tx_valid_out, tx_ready_in, blk;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, base, dout, hits, last_w;
    logic [3:0] k_o, sym, last_k;
    logic [1:0] f_o, src_field = 2'h2;
    logic [15:0] freq_dev;
    int failures = 0, compares = 0, n;
    logic [31:0] alarm_w [1:4] = '{32'hbc49bf49, 32'hbc35bf49, 32'hbc55bf45, 32'hbc358a55};
    row_t rows [13] = '{
        '{32'h110, 2, 3, 1, 20, 3}, '{32'h110, 1, 2, 1, 20, 0}, '{32'h010, 2, 2, 1, 20, 0},
        '{32'h120, 2, 2, 1, 20, 2}, '{32'h1120, 2, 2, 1, 20, 0}, '{32'h130, 2, 2, 1, 20, 2},
        '{32'h140, 3, 1, 1, 20, 1}, '{32'h10140, 3, 1, 1, 20, 0}, '{32'h2150, 2, 2, 1, 20, 2},
        '{32'h210, 2, 1, 0, 230, 4}, '{32'h310, 2, 1, 0, 1030, 2}, '{32'h410, 2, 1, 1, 250, 2},
        '{32'h510, 2, 1, 0, 2100, 2}};
    always #50 mclk_in = ~mclk_in;
    fc_error_alarm_injector #(.FIFO_DEPTH(4), .SEC_CYCLES(50), .TEN_SEC_CYCLES(500)) u_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .tx_data_in(32'h12345670), .tx_k_in(4'h0), .tx_field_in(src_field), .tx_valid_in(src_valid),
        .tx_ready_out(tx_ready_out), .tx_data_out(dout), .tx_k_out(k_o), .tx_field_out(f_o),
        .tx_sym_err_out(sym), .tx_blk_err_out(blk), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
        .tx_freq_dev_out(freq_dev));
    fc_port_model u_port (.clk_in(mclk_in), .rst_in(rst_in), .data_in(dout), .k_in(k_o), .sym_in(sym),
        .blk_in(blk), .valid_in(tx_valid_out), .ready_out(tx_ready_in), .stall_in(stall), .slow_in(slow),
        .hits_out(hits), .last_out(last_w), .last_k_out(last_k));
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic tick(input int i);
        if (i == 40)
        begin
            failures++;
            report_and_stop();
        end
        else
            @(posedge mclk_in);
    endtask : tick
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk_in);
        penable <= 1'b1;
        @(posedge mclk_in);
        for (n = 0; pready !== 1'b1; n++)
            tick(n);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    initial
    begin
        repeat (12) @(posedge mclk_in);
        chk("ready in reset", 1, {31'h0, tx_ready_out});
        chk("freq reset", 0, {16'h0, freq_dev});
        rst_in <= 1'b0;
        apb(0, fc_inj_pkg::BURST_OFS, 0);
        chk("burst reset", 1, r);
        apb(0, 8'h40, 0);
        chk("unmapped", 32'h1, {r[30:0], e});
        src_valid <= 1'b1;
        foreach (rows[i])
        begin
            src_field <= rows[i].fld;
            apb(1, fc_inj_pkg::CTRL_OFS, 0);
            apb(1, fc_inj_pkg::BURST_OFS, rows[i].len);
            apb(1, fc_inj_pkg::ERRCNT_OFS, 0);
            base = hits;
            apb(1, fc_inj_pkg::CTRL_OFS, rows[i].ctrl);
            repeat (rows[i].trig) apb(1, fc_inj_pkg::TRIG_OFS, 1);
            repeat (rows[i].cyc) @(posedge mclk_in);
            apb(1, fc_inj_pkg::CTRL_OFS, 0);
            apb(0, fc_inj_pkg::ERRCNT_OFS, 0);
            chk("error count", rows[i].exp, r);
            chk("errors seen", rows[i].exp, hits - base);
        end
        slow <= 1'b1;
        for (int a = 1; a < 5; a++)
        begin
            apb(1, fc_inj_pkg::CTRL_OFS, a);
            repeat (20) @(posedge mclk_in);
            chk("alarm word", alarm_w[a], last_w);
            chk("alarm k", 32'h8, {28'h0, last_k});
        end
        apb(1, fc_inj_pkg::CTRL_OFS, 0);
        repeat (20) @(posedge mclk_in);
        chk("traffic back", 32'h12345670, last_w);
        chk("field back", 2, {30'h0, f_o});
        {slow, stall} <= 2'b01;
        repeat (12) @(posedge mclk_in);
        chk("fifo full", 0, {31'h0, tx_ready_out});
        {src_valid, stall} <= 2'b00;
        for (n = 0; tx_valid_out !== 1'b0; n++)
            tick(n);
        chk("fifo drained", 1, {31'h0, tx_ready_out});
        apb(1, fc_inj_pkg::FREQ_OFS, 32'hff38);
        @(posedge mclk_in);
        chk("freq dev", 32'hff38, {16'h0, freq_dev});
        report_and_stop();
    end
endmodule : tb_top
